/* File: logic/eci_consts.svh */
// Offsets, field positions, reset values and timing counts for ext control.
`ifndef ECI_CONSTS_SVH
`define ECI_CONSTS_SVH
`define ECI_OFF_CTRL      8'h00
`define ECI_OFF_STATUS    8'h04
`define ECI_OFF_MASK      8'h08
`define ECI_OFF_STATE     8'h0C
`define ECI_OFF_CMD       8'h10
`define ECI_OFF_COUNT     8'h14
`define ECI_OFF_SUM       8'h18
`define ECI_OFF_LAST      8'h1C
`define ECI_OFF_MEM       8'h40
`define ECI_MEM_MASK      8'hC0
`define ECI_CTRL_EDGE_OFF 0
`define ECI_CTRL_EXT_SRC  1
`define ECI_CTRL_CAL_AUTO 2
`define ECI_CTRL_RST      3'h0
`define ECI_CMD_EXT_TRIGGER_IN      0
`define ECI_EV_EXT_TRIGGER_IN       0
`define ECI_EV_MEAS_DONE  1
`define ECI_EV_ZADJ       2
`define ECI_EV_ZADJ_FAIL  3
`define ECI_EV_PRINT      4
`define ECI_EV_CAL_START  5
`define ECI_EV_CAL_DONE   6
`define ECI_EV_W          7
`define ECI_CAL_TIME_MS   32'h0000_0190
`define ECI_CLK_HZ        32'h017D_7840
`define ECI_RESP_OKAY     2'h0
`define ECI_RESP_SLVERR   2'h2
`endif

/* File: logic/eci_pkg.sv */
// Types shared by the external control input handler.
package eci_pkg;
	typedef struct packed {
		logic       ext_trigger_in;
		logic       zero_adjust_req;
		logic       print_req;
		logic       cal_req;
		logic       panel_lock;
		logic       channel_select_mode;
		logic [5:0] preset_sel;
	} eci_ext_in_t;

	typedef struct packed {
		logic standby;
		logic enter;
		logic [5:0] other;
	} eci_keys_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_MEAS = 3'h2,
		ST_CAL  = 3'h4
	} eci_state_t;
endpackage : eci_pkg

/* File: logic/eci_top.sv */
// External control input handler with an AXI4-Lite register slave.
//
// Summary of operation
// (R01) Trigger acts on one selectable edge, on-edge default.
// (R02) External source: each trigger edge starts one measurement.
// (R03) Internal source: trigger input edges are ignored.
// (R04) Accepted trigger updates statistics and stores value.
// (R05) Enter key and remote command also trigger.
// (R06) Controller waits for settling before triggering.
// (R07) Zero-adjust off-to-on edge starts one zero adjustment.
// (R08) Controller holds zero-adjust request at least 10 ms.
// (R09) Failed zero adjustment drives fault output.
// (R10) Print request sends current value to printer.
// (R11) Manual mode: calibration edge starts one calibration.
// (R12) Automatic mode: calibration request input ignored.
// (R13) Calibration occupies the device about 400 ms.
// (R14) Calibration during measurement waits until measurement ends.
// (R15) Panel lock disables keys except standby and enter.
// (R16) Mode input selects preset or channel meaning.
// (R17) Controller holds select lines fixed otherwise.
// (R18) Inputs are synchronised before edge detection; the enter key edge is taken from keys_in unsynchronised.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "eci_consts.svh"
module eci_top #(
	parameter int CAL_CYCLES = `ECI_CAL_TIME_MS * (`ECI_CLK_HZ / 1000)
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire eci_pkg::eci_ext_in_t ext_in,
	input  wire eci_pkg::eci_keys_t keys_in,
	input  wire logic               key_unlock_in,
	input  wire logic               remote_cancel_in,
	input  wire logic               meas_done,
	input  wire logic [31:0]        meas_value,
	input  wire logic               zadj_done,
	input  wire logic               zadj_fail,
	output logic                    meas_start,
	output logic                    zadj_start,
	output logic                    print_start,
	output logic [31:0]             print_value,
	output logic                    cal_busy,
	output logic                    fault_out,
	output eci_pkg::eci_keys_t      keys_out,
	output logic                    key_unlock_out,
	output logic                    remote_cancel_out,
	output logic                    preset_valid,
	output logic [5:0]              preset_num,
	output logic                    channel_valid,
	output logic [5:0]              channel_num,
	output logic                    irq
);
	eci_pkg::eci_ext_in_t sync1_r, sync2_r, prev_r;
	eci_pkg::eci_state_t  state_r;
	logic [2:0]  ctrl_r;
	logic [`ECI_EV_W-1:0] status_r, mask_r, events;
	logic [31:0] count_r, sum_r, last_r;
	logic [31:0] mem_r [0:15];
	logic [3:0]  wptr_r;
	logic [31:0] cal_cnt_r;
	logic        cal_pend_r, remote_ext_trigger_in_r, ext_trigger_in_accept;
	logic        ext_trigger_in_edge, zadj_edge, cal_edge, print_edge, enter_edge;
	logic        enter_prev_r;
	logic        wr_fire, rd_fire;
	logic [31:0] rd_data;
	logic        rd_ok;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers and edge detectors.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r      <= '0;
			sync2_r      <= '0;
			prev_r       <= '0;
			enter_prev_r <= 1'b0;
		end else begin
			sync1_r      <= ext_in;  // [R18]
			sync2_r      <= sync1_r; // [R18]
			prev_r       <= sync2_r;
			enter_prev_r <= keys_in.enter;
		end
	end

	always_comb begin
		// The selected polarity picks the on-going or off-going edge.
		if (ctrl_r[`ECI_CTRL_EDGE_OFF]) begin // [R01]
			ext_trigger_in_edge = prev_r.ext_trigger_in & ~sync2_r.ext_trigger_in;
		end else begin
			ext_trigger_in_edge = ~prev_r.ext_trigger_in & sync2_r.ext_trigger_in;
		end
		ext_trigger_in_edge  = ext_trigger_in_edge & ctrl_r[`ECI_CTRL_EXT_SRC]; // [R02] [R03]
		zadj_edge  = ~prev_r.zero_adjust_req & sync2_r.zero_adjust_req;
		cal_edge   = ~prev_r.cal_req & sync2_r.cal_req
			& ~ctrl_r[`ECI_CTRL_CAL_AUTO]; // [R11] [R12]
		print_edge = ~prev_r.print_req & sync2_r.print_req;
		enter_edge = keys_in.enter & ~enter_prev_r;
		ext_trigger_in_accept = (ext_trigger_in_edge | enter_edge | remote_ext_trigger_in_r) // [R05]
			& (state_r == eci_pkg::ST_IDLE) & ~cal_pend_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: one measurement per accepted trigger, or one calibration when one is pending.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r    <= eci_pkg::ST_IDLE;
			cal_pend_r <= 1'b0;
			cal_cnt_r  <= '0;
			meas_start <= 1'b0;
			cal_busy   <= 1'b0;
		end else begin
			meas_start <= 1'b0;
			if (cal_edge) begin
				cal_pend_r <= 1'b1; // [R14]
			end
			case (state_r)
			eci_pkg::ST_IDLE: begin
				if (cal_pend_r) begin
					// A pending calibration starts only once idle.
					state_r    <= eci_pkg::ST_CAL; // [R14]
					cal_pend_r <= cal_edge;
					cal_cnt_r  <= 32'(CAL_CYCLES - 1);
					cal_busy   <= 1'b1;
				end else if (ext_trigger_in_accept) begin
					state_r    <= eci_pkg::ST_MEAS;
					meas_start <= 1'b1; // [R02] [R05]
				end
			end
			eci_pkg::ST_MEAS: begin
				if (meas_done) begin
					state_r <= eci_pkg::ST_IDLE;
				end
			end
			eci_pkg::ST_CAL: begin
				if (cal_cnt_r == 32'h0000_0000) begin
					state_r  <= eci_pkg::ST_IDLE;
					cal_busy <= 1'b0;
				end else begin
					cal_cnt_r <= cal_cnt_r - 32'h0000_0001; // [R13]
				end
			end
			default: begin
				state_r  <= eci_pkg::ST_IDLE;
				cal_busy <= 1'b0;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Statistics and data memory for each finished measurement.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= '0;
			sum_r   <= '0;
			last_r  <= '0;
			wptr_r  <= '0;
		end else if (meas_done && state_r == eci_pkg::ST_MEAS) begin
			count_r <= count_r + 32'h0000_0001; // [R04]
			sum_r   <= sum_r + meas_value;      // [R04]
			last_r  <= meas_value;
			wptr_r  <= wptr_r + 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (meas_done && state_r == eci_pkg::ST_MEAS) begin
			mem_r[wptr_r] <= meas_value; // [R04]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Zero adjustment, printing and fault output.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zadj_start  <= 1'b0;
			print_start <= 1'b0;
			print_value <= '0;
			fault_out   <= 1'b0;
		end else begin
			zadj_start  <= zadj_edge;  // [R07]
			print_start <= print_edge; // [R10]
			if (print_edge) begin
				print_value <= last_r; // [R10]
			end
			if (zadj_done && zadj_fail) begin
				fault_out <= 1'b1; // [R09]
			end else if (zadj_edge) begin
				fault_out <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Key lock gating and preset or channel decode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			keys_out          <= '0;
			key_unlock_out    <= 1'b0;
			remote_cancel_out <= 1'b0;
			preset_valid      <= 1'b0;
			channel_valid     <= 1'b0;
			preset_num        <= '0;
			channel_num       <= '0;
		end else begin
			keys_out.standby  <= keys_in.standby;
			keys_out.enter    <= keys_in.enter;
			keys_out.other    <= sync2_r.panel_lock ? 6'h00
				: keys_in.other; // [R15]
			key_unlock_out    <= key_unlock_in & ~sync2_r.panel_lock; // [R15]
			remote_cancel_out <= remote_cancel_in
				& ~sync2_r.panel_lock; // [R15]
			preset_valid  <= ~sync2_r.channel_select_mode; // [R16]
			channel_valid <= sync2_r.channel_select_mode;  // [R16]
			if (sync2_r.channel_select_mode) begin
				channel_num <= sync2_r.preset_sel; // [R16]
			end else begin
				preset_num <= sync2_r.preset_sel; // [R16]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky event flags, mask and interrupt.
	always_comb begin
		events = '0;
		events[`ECI_EV_EXT_TRIGGER_IN]      = meas_start;
		events[`ECI_EV_MEAS_DONE] = meas_done & (state_r == eci_pkg::ST_MEAS);
		events[`ECI_EV_ZADJ]      = zadj_done;
		events[`ECI_EV_ZADJ_FAIL] = zadj_done & zadj_fail;
		events[`ECI_EV_PRINT]     = print_start;
		events[`ECI_EV_CAL_START] = (state_r == eci_pkg::ST_IDLE) & cal_pend_r;
		events[`ECI_EV_CAL_DONE]  = (state_r == eci_pkg::ST_CAL)
			& (cal_cnt_r == 32'h0000_0000);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r <= '0;
			irq      <= 1'b0;
		end else begin
			// A new event in the clearing cycle stays set.
			if (rd_fire && s_axi_araddr == `ECI_OFF_STATUS) begin
				status_r <= events;
			end else begin
				status_r <= status_r | events;
			end
			irq <= |((status_r | events) & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave.
	assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
		& ~s_axi_bvalid;
	assign rd_fire = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ECI_RESP_OKAY;
			ctrl_r        <= `ECI_CTRL_RST;
			mask_r        <= '0;
			remote_ext_trigger_in_r <= 1'b0;
		end else begin
			s_axi_awready <= wr_fire;
			s_axi_wready  <= wr_fire;
			remote_ext_trigger_in_r <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `ECI_RESP_OKAY;
				case (s_axi_awaddr)
				`ECI_OFF_CTRL: begin
					if (s_axi_wstrb[0]) begin
						ctrl_r <= s_axi_wdata[2:0]; // [R01]
					end
				end
				`ECI_OFF_MASK: begin
					if (s_axi_wstrb[0]) begin
						mask_r <= s_axi_wdata[`ECI_EV_W-1:0];
					end
				end
				`ECI_OFF_CMD: begin
					remote_ext_trigger_in_r <= s_axi_wstrb[0]
						& s_axi_wdata[`ECI_CMD_EXT_TRIGGER_IN]; // [R05]
				end
				`ECI_OFF_STATUS, `ECI_OFF_STATE, `ECI_OFF_COUNT,
				`ECI_OFF_SUM, `ECI_OFF_LAST: begin
				end
				default: begin
					if ((s_axi_awaddr & `ECI_MEM_MASK) != `ECI_OFF_MEM) begin
						s_axi_bresp <= `ECI_RESP_SLVERR;
					end
				end
				endcase
			end
		end
	end

	always_comb begin
		rd_ok   = 1'b1;
		rd_data = '0;
		case (s_axi_araddr)
		`ECI_OFF_CTRL:   rd_data = {29'h0000_0000, ctrl_r};
		`ECI_OFF_STATUS: rd_data = {25'h000_0000, status_r};
		`ECI_OFF_MASK:   rd_data = {25'h000_0000, mask_r};
		`ECI_OFF_STATE:  rd_data = {16'h0000, 2'h0, sync2_r.preset_sel,
			sync2_r.channel_select_mode, sync2_r.panel_lock,
			fault_out, cal_pend_r, 1'b0, state_r};
		`ECI_OFF_CMD:    rd_data = '0;
		`ECI_OFF_COUNT:  rd_data = count_r;
		`ECI_OFF_SUM:    rd_data = sum_r;
		`ECI_OFF_LAST:   rd_data = last_r;
		default: begin
			if ((s_axi_araddr & `ECI_MEM_MASK) == `ECI_OFF_MEM) begin
				rd_data = mem_r[s_axi_araddr[5:2]];
			end else begin
				rd_ok = 1'b0;
			end
		end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `ECI_RESP_OKAY;
		end else begin
			s_axi_arready <= rd_fire;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_ok ? `ECI_RESP_OKAY : `ECI_RESP_SLVERR;
			end
		end
	end
endmodule : eci_top

/* File: verif/eci_top_assertions.sv */
// Concurrent checks on the ports of the external control input handler.
`timescale 1ns/1ps
module eci_top_assertions #(
	parameter int CAL_CYCLES = 20
) (
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire eci_pkg::eci_ext_in_t ext_in,
	input wire logic                 meas_done,
	input wire logic [31:0]          meas_value,
	input wire logic                 zadj_done,
	input wire logic                 zadj_fail,
	input wire logic                 meas_start,
	input wire logic                 zadj_start,
	input wire logic                 print_start,
	input wire logic [31:0]          print_value,
	input wire logic                 cal_busy,
	input wire logic                 fault_out,
	input wire eci_pkg::eci_keys_t   keys_out,
	input wire logic                 key_unlock_out,
	input wire logic                 remote_cancel_out,
	input wire logic                 preset_valid,
	input wire logic                 channel_valid
);
	logic        meas_on_r;
	logic [31:0] last_val_r;
	int          cal_cnt_r;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn || meas_done)
			meas_on_r <= 1'b0;
		else if (meas_start)
			meas_on_r <= 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			last_val_r <= 32'h0000_0000;
		else if (meas_done)
			last_val_r <= meas_value;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !cal_busy)
			cal_cnt_r <= 0;
		else
			cal_cnt_r <= cal_cnt_r + 1;
	end

	////////////////////////////////////////////////////////////////////////
	a_one_meas: assert property (meas_start |-> !meas_on_r)
		else $error("Measurement started while another runs.");
	a_zadj_once: assert property (zadj_start |=> !zadj_start)
		else $error("Zero adjust start longer than one cycle.");
	a_fault_set: assert property (zadj_done && zadj_fail |=> fault_out)
		else $error("Fault output missing after failed zero adjust.");
	a_print_val: assert property (print_start |-> print_value == last_val_r)
		else $error("Printed value is not the last measured value.");
	a_cal_len: assert property ($fell(cal_busy)
		|-> cal_cnt_r == CAL_CYCLES)
		else $error("Calibration busy length is wrong.");
	a_cal_wait: assert property ($rose(cal_busy) |-> !meas_on_r)
		else $error("Calibration started during a measurement.");
	a_cal_excl: assert property (cal_busy |-> !meas_start)
		else $error("Measurement started during calibration.");
	a_lock_keys: assert property (ext_in.panel_lock [*5] |-> keys_out.other == 6'h00
		&& !key_unlock_out && !remote_cancel_out)
		else $error("Locked keys were passed through.");
	a_mode_sel: assert property (ext_in.channel_select_mode [*5]
		|-> channel_valid && !preset_valid)
		else $error("Select lines not read as channel number.");

	c_meas: cover property (meas_start);
	c_cal: cover property ($fell(cal_busy));
	c_fault: cover property ($rose(fault_out));
endmodule : eci_top_assertions

bind eci_top eci_top_assertions #(.CAL_CYCLES(CAL_CYCLES)) u_eci_top_assertions (
	.aclk(aclk), .aresetn(aresetn), .ext_in(ext_in), .meas_done(meas_done),
	.meas_value(meas_value), .zadj_done(zadj_done), .zadj_fail(zadj_fail),
	.meas_start(meas_start), .zadj_start(zadj_start),
	.print_start(print_start), .print_value(print_value),
	.cal_busy(cal_busy), .fault_out(fault_out), .keys_out(keys_out),
	.key_unlock_out(key_unlock_out), .remote_cancel_out(remote_cancel_out),
	.preset_valid(preset_valid), .channel_valid(channel_valid)
);

/* File: verif/eci_ctrl_model.sv */
// Model of the external controller and of the measurement and zero-adjust units.
`timescale 1ns/1ps
module eci_ctrl_model #(
	parameter int MEAS_LAT = 20,
	parameter int HOLD     = 8
) (
	input  wire logic            aclk,
	input  wire logic            meas_start,
	input  wire logic            zadj_start,
	output eci_pkg::eci_ext_in_t ext_in,
	output logic                 meas_done,
	output logic [31:0]          meas_value,
	output logic                 zadj_done,
	output logic                 zadj_fail
);
	logic [31:0] nval;
	logic        zfail;
	int          m_cnt;
	int          z_cnt;

	initial begin
		ext_in = '0;
		nval = 32'h0000_0000;
		zfail = 1'b0;
		m_cnt = 0;
		z_cnt = 0;
	end

	// Every level, select lines included, stays put for HOLD cycles.
	task automatic set(input eci_pkg::eci_ext_in_t v);
		@(posedge aclk);
		ext_in <= v;
		repeat (HOLD) @(posedge aclk);
	endtask : set

	always @(posedge aclk) begin
		m_cnt <= meas_start ? MEAS_LAT : (m_cnt != 0 ? m_cnt - 1 : 0);
		z_cnt <= zadj_start ? 3 : (z_cnt != 0 ? z_cnt - 1 : 0);
	end

	// Result lines carry the inverse of their value outside their valid cycle.
	assign meas_done = (m_cnt == 1);
	assign meas_value = meas_done ? nval : ~nval;
	assign zadj_done = (z_cnt == 1);
	assign zadj_fail = zadj_done ? zfail : ~zfail;
endmodule : eci_ctrl_model

/* File: verif/ext_control_input_handler_bench.sv */
// Self-checking bench for the external control input handler.
`timescale 1ns/1ps
module ext_control_input_handler_bench;
	localparam logic [11:0] TG = 12'h800, ZA = 12'h400, PR = 12'h200;
	localparam logic [11:0] CL = 12'h100, LK = 12'h080, MX = 12'h040;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready, irq, cal_busy;
	logic        meas_start, zadj_start, print_start, meas_done, zadj_done;
	logic        zadj_fail, fault_out, key_unlock_in, key_unlock_out;
	logic        preset_valid, channel_valid, rc_in, rc_out;
	logic [1:0]  rresp, bresp, br_exp;
	logic [3:0]  wstrb;
	logic [5:0]  preset_num, channel_num, p;
	logic [7:0]  awaddr, araddr, k;
	logic [11:0] ei;
	logic [31:0] wdata, rdata, print_value, meas_value, sum, nv;
	logic [2:0]  exp_ev[$];
	logic [33:0] exp_rd[$];
	int          seed, n_mismatch, tests_run, i;
	eci_pkg::eci_keys_t   keys_in, keys_out;
	eci_pkg::eci_ext_in_t ext_in;

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	eci_top #(.CAL_CYCLES(20)) u_eci_top (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_in(ext_in), .keys_in(keys_in),
		.key_unlock_in(key_unlock_in), .remote_cancel_in(rc_in),
		.meas_done(meas_done), .meas_value(meas_value),
		.zadj_done(zadj_done), .zadj_fail(zadj_fail),
		.meas_start(meas_start), .zadj_start(zadj_start),
		.print_start(print_start), .print_value(print_value),
		.cal_busy(cal_busy), .fault_out(fault_out), .keys_out(keys_out),
		.key_unlock_out(key_unlock_out), .remote_cancel_out(rc_out),
		.preset_valid(preset_valid), .preset_num(preset_num),
		.channel_valid(channel_valid), .channel_num(channel_num), .irq(irq)
	);

	eci_ctrl_model #(.MEAS_LAT(20), .HOLD(8)) u_eci_ctrl_model (
		.aclk(aclk), .meas_start(meas_start), .zadj_start(zadj_start),
		.ext_in(ext_in), .meas_done(meas_done), .meas_value(meas_value),
		.zadj_done(zadj_done), .zadj_fail(zadj_fail)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task finish_test;
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (!bvalid) @(posedge aclk);
		chk(bresp, br_exp);
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [33:0] e);
		exp_rd.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge aclk);
		rready <= 1'b0;
	endtask : rd

	task drv(input logic [11:0] m);
		ei = ei ^ m;
		u_eci_ctrl_model.set(ei);
	endtask : drv

	task meas_by(input logic [11:0] m);
		nv = $random(seed);
		u_eci_ctrl_model.nval = nv;
		sum = sum + nv;
		exp_ev.push_back(3'h1);
		drv(m);
		repeat (24) @(posedge aclk);
	endtask : meas_by

	task wt(input logic v);
		for (i = 0; i < 100 && cal_busy !== v; i++) @(posedge aclk);
		chk(cal_busy, v);
	endtask : wt

	////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		if (meas_start | zadj_start | print_start)
			chk({print_start, zadj_start, meas_start},
				exp_ev.size() ? exp_ev.pop_front() : 3'h0);
		if (rvalid && rready)
			chk({rresp, rdata}, exp_rd.pop_front());
	end

	initial begin
		repeat (5000) @(posedge aclk);
		n_mismatch++;
		finish_test();
	end

	initial begin
		seed = 32'h3316_67a2;
		{n_mismatch, tests_run, sum, ei, keys_in, key_unlock_in} = '0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, rc_in} = '0;
		br_exp = 2'h0;
		wstrb = 4'hF;
		{awaddr, araddr, wdata} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 34'h0);
		rd(8'h0C, 34'h1);
		drv(TG);
		drv(TG);
		wr(8'h00, 32'h0000_0002);
		for (int j = 0; j < 2; j++) begin
			meas_by(TG);
			drv(TG);
		end
		wr(8'h00, 32'h0000_0003);
		drv(TG);
		meas_by(TG);
		rd(8'h14, 34'h3);
		rd(8'h18, {2'h0, sum});
		rd(8'h1C, {2'h0, nv});
		rd(8'h48, {2'h0, nv});
		exp_ev.push_back(3'h1);
		wr(8'h10, 32'h0000_0001);
		repeat (30) @(posedge aclk);
		exp_ev.push_back(3'h1);
		keys_in <= 8'h40;
		repeat (2) @(posedge aclk);
		keys_in <= 8'h00;
		repeat (30) @(posedge aclk);
		drv(LK);
		k = $random(seed);
		keys_in <= {k[7], 1'b0, k[5:0]};
		key_unlock_in <= 1'b1;
		rc_in <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(keys_out, {k[7], 7'h00});
		chk({key_unlock_out, rc_out}, 2'h0);
		keys_in <= 8'h00;
		drv(LK);
		chk({key_unlock_out, rc_out}, 2'h3);
		key_unlock_in <= 1'b0;
		rc_in <= 1'b0;
		u_eci_ctrl_model.zfail = 1'b1;
		exp_ev.push_back(3'h2);
		drv(ZA);
		repeat (4) @(posedge aclk);
		chk(fault_out, 1'b1);
		drv(ZA);
		exp_ev.push_back(3'h4);
		drv(PR);
		chk(print_value, nv);
		drv(PR);
		p = $random(seed);
		ei[5:0] = p;
		drv(MX);
		chk({channel_valid, channel_num}, {1'b1, p});
		drv(MX);
		chk({preset_valid, preset_num}, {1'b1, p});
		drv(CL);
		wt(1'b1);
		wt(1'b0);
		drv(CL);
		wr(8'h00, 32'h0000_0006);
		drv(CL);
		repeat (10) @(posedge aclk);
		chk(cal_busy, 1'b0);
		drv(CL);
		wr(8'h00, 32'h0000_0002);
		exp_ev.push_back(3'h1);
		drv(TG);
		drv(CL);
		chk(cal_busy, 1'b0);
		wt(1'b1);
		wt(1'b0);
		wr(8'h08, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		rd(8'h04, 34'h7F);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		rd(8'h04, 34'h0);
		rd(8'h30, 34'h2_0000_0000);
		br_exp = 2'h2;
		wr(8'h30, 32'h0000_0001);
		br_exp = 2'h0;
		wstrb <= 4'hE;
		wr(8'h00, 32'h0000_0000);
		wstrb <= 4'hF;
		rd(8'h00, 34'h2);
		repeat (4) @(posedge aclk);
		chk(exp_ev.size(), 34'h0);
		finish_test();
	end
endmodule : ext_control_input_handler_bench
